/* File: rgd_pkg.sv */
// rgd_pkg: register map, field positions and shared types of the receive gain and demodulation block
// assumes a 32-bit AXI4-Lite register bus and a 10-bit divider code on the analog side
package rgd_pkg;
  // register byte offsets
  localparam logic [7:0] RGD_OFS_DEMOD = 8'hbc;
  localparam logic [7:0] RGD_OFS_THRES = 8'hc0;
  localparam logic [7:0] RGD_OFS_GCFG = 8'hcc;
  localparam logic [7:0] RGD_OFS_GSTAT = 8'hd4;
  localparam logic [7:0] RGD_OFS_RSSI = 8'hd8;
  // demodulation control fields
  localparam int RGD_BIT_GRID = 2;
  localparam int RGD_BIT_FSK = 1;
  localparam int RGD_BIT_BPSK = 0;
  // threshold fields
  localparam int RGD_EDGE_LSB = 16;
  localparam int RGD_EDGE_MSB = 28;
  localparam int RGD_BITTH_LSB = 0;
  localparam int RGD_BITTH_MSB = 12;
  // gain configuration fields
  localparam int RGD_PER_LSB = 5;
  localparam int RGD_PER_MSB = 14;
  localparam int RGD_BIT_SRC = 3;
  localparam int RGD_BIT_LOAD = 2;
  localparam int RGD_BIT_AUTO = 1;
  localparam int RGD_BIT_EN = 0;
  // static gain fields
  localparam int RGD_RM_LSB = 16;
  localparam int RGD_RM_MSB = 25;
  localparam int RGD_CM_LSB = 0;
  localparam int RGD_CM_MSB = 9;
  // readback fields
  localparam int RGD_RG_LSB = 6;
  localparam int RGD_RG_MSB = 15;
  localparam int RGD_ADQ_MSB = 5;
  // reset values and gain extremes
  localparam logic [31:0] RGD_RST_WORD = 32'h0000_0000;
  localparam logic [9:0] RGD_GAIN_MIN = 10'h000;
  localparam logic [9:0] RGD_GAIN_MAX = 10'h3ff;
  localparam logic [9:0] RGD_CNT_ZERO = 10'h000;
  // axi response codes
  localparam logic [1:0] RGD_RESP_OKAY = 2'b00;
  localparam logic [1:0] RGD_RESP_SLVERR = 2'b10;

  // demodulator configuration bundle
  typedef struct packed {
    logic grid_at_max;
    logic fsk_sel;
    logic bpsk_sel;
    logic [12:0] edge_decision_threshold;
    logic [12:0] bit_decision_threshold;
  } rgd_demod_t;

  // received level indication from the front end
  typedef struct packed {
    logic too_high;
    logic too_low;
  } rgd_level_t;
endpackage : rgd_pkg

/* File: rgd_top.sv */
// rgd_top: register bank for receive demodulation, decision thresholds and automatic gain control
// assumes aclk at 100 MHz for the bus side and a 13.56 MHz carrier clock sampled as a plain input;
// analog level flags and adc sample arrive asynchronously and are synchronised here
// the level flags are steady for many bus cycles, so a bitwise two-flop synchroniser is enough;
// the q sample is synchronised bit by bit too, so a readback taken while it moves may mix two samples
// the divider code is registered so the switch network never sees a decode glitch
// a gain load takes the source select that is already held, not one written alongside it,
// so software sets the source in an earlier write than the load
// the demodulator settings are plain register outputs and change only on a committed write
`timescale 1ns/1ns
module rgd_top
  import rgd_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // analog front end inputs (asynchronous)
  input wire logic carrier_clk,
  input wire logic [5:0] adc_q_sample,
  input wire logic [1:0] rx_level_flags,
  // outputs to the demodulator and the divider
  output rgd_demod_t demod_cfg,
  output logic [9:0] rx_divider_code
);

  // registers
  logic [2:0] demod_r; // grid, fsk, bpsk control bits
  logic [12:0] edge_th_r; // edge decision threshold
  logic [12:0] bit_th_r; // bit decision threshold
  logic [9:0] period_r; // gain period count field
  logic src_r; // gain source select
  logic auto_r; // gain auto select
  logic en_r; // gain loop enable
  logic [9:0] rm_r; // reader static gain
  logic [9:0] cm_r; // card static gain
  logic [9:0] loop_gain_r; // internal gain loop register
  logic [9:0] div_r; // value applied to the divider
  logic [9:0] per_cnt_r; // carrier edges within the period
  // synchronisers
  logic cclk_s1_r; // carrier clock, first stage
  logic [2:0] cclk_s2_r; // second stage, then edge history
  logic [5:0] adc_s1_r, adc_s2_r; // q sample
  logic [1:0] lvl_s1_r, lvl_s2_r; // level flags
  rgd_level_t lvl; // decoded level flags
  // bus state
  logic aw_got_r, w_got_r; // address or data already taken
  logic [7:0] aw_addr_r; // held write address
  logic [31:0] w_data_r; // held write data
  logic [3:0] w_strb_r; // held strobes
  logic [31:0] rd_word; // decoded read word
  logic rd_hit; // read address maps a register
  logic wr_hit; // write address maps a register
  logic do_wr; // write commits this cycle
  logic [31:0] wmask; // byte-enable mask
  logic load_pulse; // single gain load request
  logic carrier_edge; // rising carrier edge seen
  logic period_tick; // end of gain period
  logic [9:0] static_sel; // chosen static value
  logic [9:0] div_nxt; // next divider value

  // two-flop synchronisers for asynchronous front-end signals
  // only the second stage reads the first; nothing else looks at a first stage
  // the carrier history keeps two extra bits so a rising edge is seen as 0 then 1
  // after reset all stages read low, so a carrier that is high then gives one early edge,
  // which is harmless because the period counter is held clear until the loop is enabled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cclk_s1_r <= 1'b0;
      cclk_s2_r <= 3'h0;
      adc_s1_r <= 6'h00;
      adc_s2_r <= 6'h00;
      lvl_s1_r <= 2'h0;
      lvl_s2_r <= 2'h0;
    end else begin
      cclk_s1_r <= carrier_clk;
      cclk_s2_r <= {cclk_s2_r[1:0], cclk_s1_r};
      adc_s1_r <= adc_q_sample;
      adc_s2_r <= adc_s1_r;
      lvl_s1_r <= rx_level_flags;
      lvl_s2_r <= lvl_s1_r;
    end
  end

  assign lvl = rgd_level_t'(lvl_s2_r);
  // edge is judged on the third and fourth stages only
  assign carrier_edge = cclk_s2_r[1] & ~cclk_s2_r[2];

  // write channel handshakes; each side is taken independently
  // a half that arrives first is held until its partner comes, in either order
  // both readies stay low while a response waits, so at most one write is open
  // and the held address and data cannot change under the commit
  assign s_axi_awready = ~aw_got_r & ~s_axi_bvalid;
  assign s_axi_wready = ~w_got_r & ~s_axi_bvalid;
  assign do_wr = aw_got_r & w_got_r & ~s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= RGD_RST_WORD;
      w_strb_r <= 4'h0;
    end else begin
      // address capture
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end else if (do_wr) begin
        aw_got_r <= 1'b0;
      end
      // data capture
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end else if (do_wr) begin
        w_got_r <= 1'b0;
      end
    end
  end

  // write response, one cycle after both halves are held
  // the response code is judged from the held address, so an unmapped write
  // answers with an error and leaves every register untouched
  // the response stands until the master takes it with bready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RGD_RESP_OKAY;
    end else if (do_wr) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? RGD_RESP_OKAY : RGD_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // write decode and byte mask
  // each byte strobe opens eight bits of the mask; fields that span bytes
  // are merged bit by bit, so a partial write keeps the bytes it does not name
  // the readback register is mapped so that writes to it answer okay and are ignored
  always_comb begin
    wmask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
    case (aw_addr_r)
      RGD_OFS_DEMOD, RGD_OFS_THRES, RGD_OFS_GCFG, RGD_OFS_GSTAT, RGD_OFS_RSSI: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // write-only load bit produces a pulse and stores nothing
  assign load_pulse = do_wr && (aw_addr_r == RGD_OFS_GCFG) && w_strb_r[0] && w_data_r[RGD_BIT_LOAD];

  // demodulation control and thresholds
  // the three demodulation bits sit in byte 0 and follow its strobe only
  // reserved bits between and above the thresholds are never stored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      demod_r <= 3'h0;
      edge_th_r <= 13'h0000;
      bit_th_r <= 13'h0000;
    end else if (do_wr) begin
      if (aw_addr_r == RGD_OFS_DEMOD && w_strb_r[0]) begin
        demod_r <= w_data_r[RGD_BIT_GRID:RGD_BIT_BPSK];
      end
      if (aw_addr_r == RGD_OFS_THRES) begin
        edge_th_r <= (edge_th_r & ~wmask[RGD_EDGE_MSB:RGD_EDGE_LSB])
                   | (w_data_r[RGD_EDGE_MSB:RGD_EDGE_LSB] & wmask[RGD_EDGE_MSB:RGD_EDGE_LSB]);
        bit_th_r <= (bit_th_r & ~wmask[RGD_BITTH_MSB:RGD_BITTH_LSB])
                  | (w_data_r[RGD_BITTH_MSB:RGD_BITTH_LSB] & wmask[RGD_BITTH_MSB:RGD_BITTH_LSB]);
      end
    end
  end

  // gain configuration register
  // the load bit is not stored here; it only forms the pulse above
  // source, auto and enable bits share byte 0 and follow its strobe
  // the period field spans bytes 0 and 1 and is merged through the mask
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      period_r <= 10'h000;
      src_r <= 1'b0;
      auto_r <= 1'b0;
      en_r <= 1'b0;
    end else if (do_wr && aw_addr_r == RGD_OFS_GCFG) begin
      period_r <= (period_r & ~wmask[RGD_PER_MSB:RGD_PER_LSB])
                | (w_data_r[RGD_PER_MSB:RGD_PER_LSB] & wmask[RGD_PER_MSB:RGD_PER_LSB]);
      if (w_strb_r[0]) begin
        src_r <= w_data_r[RGD_BIT_SRC];
        auto_r <= w_data_r[RGD_BIT_AUTO];
        en_r <= w_data_r[RGD_BIT_EN];
      end
    end
  end

  // static gain values
  // both values are held even while the loop drives the divider,
  // so a later switch back to static mode picks them up at once
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rm_r <= 10'h000;
      cm_r <= 10'h000;
    end else if (do_wr && aw_addr_r == RGD_OFS_GSTAT) begin
      rm_r <= (rm_r & ~wmask[RGD_RM_MSB:RGD_RM_LSB])
            | (w_data_r[RGD_RM_MSB:RGD_RM_LSB] & wmask[RGD_RM_MSB:RGD_RM_LSB]);
      cm_r <= (cm_r & ~wmask[RGD_CM_MSB:RGD_CM_LSB])
            | (w_data_r[RGD_CM_MSB:RGD_CM_LSB] & wmask[RGD_CM_MSB:RGD_CM_LSB]);
    end
  end

  // gain period counter in carrier cycles
  // the counter runs from zero to the period field and then wraps, so one
  // period spans the field plus one carrier edges; a field of zero ticks on every edge
  // it is held clear while the loop is disabled, so the first period after
  // enabling is always a full one
  // a count already above a smaller new field runs on to the top and wraps, giving one long period
  assign period_tick = en_r && carrier_edge && (per_cnt_r == period_r);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      per_cnt_r <= RGD_CNT_ZERO;
    end else if (!en_r) begin
      per_cnt_r <= RGD_CNT_ZERO;
    end else if (carrier_edge) begin
      // wraps after period field plus one carrier edges
      per_cnt_r <= (per_cnt_r == period_r) ? RGD_CNT_ZERO : per_cnt_r + 10'h001;
    end
  end

  // static source: reader value when selected, card value otherwise
  assign static_sel = src_r ? rm_r : cm_r;

  // internal gain loop register
  // the loop register keeps its value while the loop is disabled, so software can
  // preset it with a load and enable the loop afterwards
  // both level flags high, or both low, leave the value where it is
  // the step stops at either end of the code range instead of wrapping
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      loop_gain_r <= RGD_GAIN_MIN;
    end else if (load_pulse) begin
      // load wins over a step in the same cycle
      loop_gain_r <= static_sel;
    end else if (period_tick) begin
      // higher code adds resistors and lowers sensitivity
      if (lvl.too_high && !lvl.too_low && loop_gain_r != RGD_GAIN_MAX) begin
        loop_gain_r <= loop_gain_r + 10'h001;
      end else if (lvl.too_low && !lvl.too_high && loop_gain_r != RGD_GAIN_MIN) begin
        loop_gain_r <= loop_gain_r - 10'h001;
      end
    end
  end

  // divider source selection
  // the auto bit alone picks the loop; with the enable bit clear the loop simply holds
  // in static mode the source bit picks the reader or the card value
  always_comb begin
    if (auto_r) begin
      div_nxt = loop_gain_r;
    end else begin
      div_nxt = static_sel;
    end
  end

  // registered divider code: code bits map one to one onto resistor switches
  // a source change reaches the divider one clock later
  // reset leaves code zero, the most sensitive setting with no resistor added
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_r <= RGD_GAIN_MIN;
    end else begin
      div_r <= div_nxt;
    end
  end

  assign rx_divider_code = div_r;

  // demodulator outputs come straight from registers
  assign demod_cfg = '{grid_at_max: demod_r[RGD_BIT_GRID], fsk_sel: demod_r[RGD_BIT_FSK],
                       bpsk_sel: demod_r[RGD_BIT_BPSK], edge_decision_threshold: edge_th_r,
                       bit_decision_threshold: bit_th_r};

  // read decode; reserved bits and the load bit read as zero
  // the decode works on the live read address; the word is captured when the address is taken
  // the readback shows the registered divider code, the value the switches really see
  always_comb begin
    rd_word = RGD_RST_WORD;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      RGD_OFS_DEMOD: rd_word[RGD_BIT_GRID:RGD_BIT_BPSK] = demod_r;
      RGD_OFS_THRES: begin
        rd_word[RGD_EDGE_MSB:RGD_EDGE_LSB] = edge_th_r;
        rd_word[RGD_BITTH_MSB:RGD_BITTH_LSB] = bit_th_r;
      end
      RGD_OFS_GCFG: begin
        rd_word[RGD_PER_MSB:RGD_PER_LSB] = period_r;
        rd_word[RGD_BIT_SRC] = src_r;
        rd_word[RGD_BIT_AUTO] = auto_r;
        rd_word[RGD_BIT_EN] = en_r;
      end
      RGD_OFS_GSTAT: begin
        rd_word[RGD_RM_MSB:RGD_RM_LSB] = rm_r;
        rd_word[RGD_CM_MSB:RGD_CM_LSB] = cm_r;
      end
      RGD_OFS_RSSI: begin
        rd_word[RGD_RG_MSB:RGD_RG_LSB] = div_r;
        rd_word[RGD_ADQ_MSB:0] = adc_s2_r;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  // read channel: one cycle from address to data
  // a new address is refused while read data waits, so one read at most is open
  // and the held read data cannot be overwritten before it is taken
  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= RGD_RST_WORD;
      s_axi_rresp <= RGD_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? RGD_RESP_OKAY : RGD_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : rgd_top

/* File: rgd_top_properties.sv */
// checker: bus handshake, reset and readback properties of rgd_top
// assumes it is bound to rgd_top and sees only its ports, one clock aclk
`timescale 1ns/1ns
module rgd_top_properties
  import rgd_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // block outputs
  input wire rgd_demod_t demod_cfg,
  input wire logic [9:0] rx_divider_code
);
  logic [7:0] ra_r; // address of the read in flight
  // keep the taken read address for the readback check
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) begin
      ra_r <= s_axi_araddr;
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  r_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data shown again after it was taken");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped before taken");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped or changed before taken");
  rd_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  wr_lat_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  gain_rst_a: assert property ($rose(aresetn) |-> rx_divider_code == RGD_GAIN_MIN && demod_cfg == '0)
    else $error("outputs not cleared by reset");
  rssi_gain_a: assert property ($rose(s_axi_rvalid) && ra_r == RGD_OFS_RSSI |->
    s_axi_rdata[15:6] == $past(rx_divider_code) && s_axi_rdata[31:16] == 16'h0000)
    else $error("readback gain differs from divider");
  cfg_commit_a: assert property ($changed(demod_cfg) |-> $rose(s_axi_bvalid))
    else $error("demodulator settings changed without a write");
endmodule : rgd_top_properties
bind rgd_top rgd_top_properties chk_i (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .demod_cfg, .rx_divider_code);

/* File: rgd_fe_model.sv */
// front end model: carrier clock, q channel sample and level flags
// assumes the bench commands the level and sample it wants seen
`timescale 1ns/1ns
module rgd_fe_model
  import rgd_pkg::*;
(
  // commands from the bench
  input wire rgd_level_t lvl_cmd,
  input wire logic [5:0] adc_cmd,
  // lines into the block
  output logic carrier_clk,
  output logic [5:0] adc_q_sample,
  output logic [1:0] rx_level_flags
);
  initial carrier_clk = 1'b0; // carrier starts low
  // about 13.56 mhz carrier, runs free like the field
  always #37 carrier_clk = ~carrier_clk;
  assign adc_q_sample = adc_cmd; // sample the block reports
  assign rx_level_flags = lvl_cmd; // bit1 too high, bit0 too low
endmodule : rgd_fe_model

/* File: tb_top.sv */
// testbench: register access, demod outputs and gain loop of rgd_top
// assumes aclk 100 mhz and the front end model on the analog side
`timescale 1ns/1ns
module tb_top import rgd_pkg::*;;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rx_level_flags;
  logic [31:0] s_axi_rdata;
  logic carrier_clk;
  logic [5:0] adc_q_sample;
  rgd_demod_t demod_cfg;
  logic [9:0] rx_divider_code;
  rgd_level_t lvl = '0; // level the front end reports
  logic [5:0] adc = 6'h00; // q sample the front end reports
  int miscompares = 0;
  int num_checks = 0;
  always #5 aclk = ~aclk;
  rgd_fe_model fe (.lvl_cmd(lvl), .adc_cmd(adc), .carrier_clk, .adc_q_sample, .rx_level_flags);
  rgd_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .carrier_clk, .adc_q_sample,
    .rx_level_flags, .demod_cfg, .rx_divider_code);
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic stop_test();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test
  // a wait ran out: count it and end the run
  task automatic tmo(input string nm);
    miscompares++;
    $display("FAIL %s expected answer seen timeout", nm);
    stop_test();
  endtask : tmo
  // one write, response compared with the expected code
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RGD_RESP_OKAY);
    int n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1; // ready held until the response is seen
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (n > 50) tmo("write");
    end while (!s_axi_bvalid);
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    s_axi_bready <= 1'b0;
  endtask : wr
  // one read, data and response compared
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm,
    input logic [1:0] er = RGD_RESP_OKAY);
    int n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1; // ready held until read data is seen
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (n > 50) tmo("read");
    end while (!s_axi_rvalid);
    chk(nm, e, s_axi_rdata);
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    s_axi_rready <= 1'b0;
  endtask : rdc
  // wait a bounded time for a divider code, then compare
  task automatic wdiv(input logic [9:0] e, input string nm);
    int n = 0;
    while (rx_divider_code !== e && n < 200) begin
      @(posedge aclk);
      n++;
    end
    chk(nm, {22'h0, e}, {22'h0, rx_divider_code});
  endtask : wdiv
  task automatic t_reset();
    rdc(RGD_OFS_DEMOD, RGD_RST_WORD, "demod_rst");
    rdc(RGD_OFS_THRES, RGD_RST_WORD, "thres_rst");
    rdc(RGD_OFS_GCFG, RGD_RST_WORD, "gcfg_rst");
    rdc(RGD_OFS_GSTAT, RGD_RST_WORD, "gstat_rst");
    rdc(RGD_OFS_RSSI, RGD_RST_WORD, "rssi_rst");
    chk("div_rst", 32'h0, {22'h0, rx_divider_code});
  endtask : t_reset
  task automatic t_demod();
    for (int i = 0; i < 3; i++) begin
      wr(RGD_OFS_DEMOD, 32'h1 << i);
      chk("demod_sel", 32'h1 << i, {29'h0, demod_cfg[28:26]});
    end
  endtask : t_demod
  task automatic t_thres();
    wr(RGD_OFS_THRES, 32'hfaaa_f555);
    rdc(RGD_OFS_THRES, 32'h1aaa_1555, "thres_rb");
    chk("edge_th", 32'h1aaa, {19'h0, demod_cfg.edge_decision_threshold});
    chk("bit_th", 32'h1555, {19'h0, demod_cfg.bit_decision_threshold});
    s_axi_wstrb <= 4'h3; // low bytes only: the edge threshold keeps its value
    wr(RGD_OFS_THRES, 32'h0000_0000);
    s_axi_wstrb <= 4'hf;
    rdc(RGD_OFS_THRES, 32'h1aaa_0000, "thres_strb");
  endtask : t_thres
  task automatic t_static();
    adc <= 6'h2d;
    wr(RGD_OFS_GSTAT, 32'hfd55_feaa);
    rdc(RGD_OFS_GSTAT, 32'h0155_02aa, "gstat_rb");
    wdiv(10'h2aa, "card_div");
    wr(RGD_OFS_GCFG, 32'h0000_0008);
    wdiv(10'h155, "reader_div");
    rdc(RGD_OFS_RSSI, {16'h0, 10'h155, 6'h2d}, "rssi_rb");
    wr(8'h40, 32'hffff_ffff, RGD_RESP_SLVERR);
    rdc(8'h40, 32'h0, "unmapped", RGD_RESP_SLVERR);
  endtask : t_static
  task automatic t_auto();
    int n = 0;
    lvl <= 2'b10; // level too high
    wr(RGD_OFS_GSTAT, 32'h03fd_0000);
    wr(RGD_OFS_GCFG, 32'h0000_006e); // period 3, reader source, load, loop output, loop off
    wdiv(10'h3fd, "load_div");
    repeat (100) @(posedge aclk);
    chk("loop_off", 32'h3fd, {22'h0, rx_divider_code});
    rdc(RGD_OFS_GCFG, 32'h0000_006a, "load_wo");
    wr(RGD_OFS_GCFG, 32'h0000_006b);
    wdiv(10'h3fe, "step_up");
    while (rx_divider_code !== 10'h3ff && n < 200) begin
      @(posedge aclk);
      n++;
    end
    chk("step_gap", 32'h1, {31'h0, n inside {[28:31]}});
    repeat (100) @(posedge aclk);
    chk("sat_top", 32'h3ff, {22'h0, rx_divider_code});
    lvl <= 2'b01; // level too low
    wdiv(10'h3fe, "step_down");
    wr(RGD_OFS_GCFG, 32'h0000_0069);
    wdiv(10'h3fd, "static_en");
    repeat (100) @(posedge aclk);
    chk("static_hold", 32'h3fd, {22'h0, rx_divider_code});
    rdc(RGD_OFS_RSSI, {16'h0, 10'h3fd, 6'h2d}, "rssi_auto");
    wr(RGD_OFS_GSTAT, 32'h0001_0000);
    wr(RGD_OFS_GCFG, 32'h0000_006f); // period 3, reader source, load, loop output, loop on
    wdiv(10'h000, "step_floor");
    repeat (100) @(posedge aclk);
    chk("sat_floor", 32'h0, {22'h0, rx_divider_code});
  endtask : t_auto
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_demod();
    t_thres();
    t_static();
    t_auto();
    adc <= 6'h00;
    lvl <= '0;
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    stop_test();
  end
endmodule : tb_top
